// [rtl/cmsr_regs.sv]
// Overview of operation
// - Mode bits 0,1 enable bit-reversal
// - Mode bits 2-7,10 select alternate registers
// - Bit 13 saturation, bit 14 sign extension
// - Bit 15 truncate, bit 16 round 32
// - Bus-master condition only when select zero
// - Secondary bits 0-2 pick edge sensing
// - Cache disable, timer, bus lock, freeze
// - Secondary bits 15-18 set flag direction
// - Status bits 0-5,10 report ALU
// - Status 6-9 multiplier, 11-13 shifter
// - Bit test, flag mirror, compare accumulator
// - Sticky ALU and multiplier exception bits
// - Sticky circular buffer overflow bits
// - Sticky bits 21-26 report stacks
// - Stack bits ignore software writes
// - Sticky bits hold, stack bits 23,25 too; 21,22,24,26 follow levels
// - Latch, mask priority order; reset unmaskable
// - Vector is base plus four times bit
// - Fixed interrupt bit assignments
// - Reset clears latch; mask one enables
`default_nettype none
module cmsr_regs (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Status sources from the core
	input  wire logic [13:0] arithFlags,
	input  wire logic        arithValid,
	input  wire logic        bitTestResult,
	input  wire logic [7:0]  compareAccumulator,
	input  wire logic [3:0]  flagPinIn,
	input  wire logic [9:0]  stickyEvents,
	input  wire logic [5:0]  stackLevels,
	input  wire logic [2:0]  extReqN,
	input  wire logic        busMasterIn,
	input  wire logic        vecTableInternal,
	// Sequencer handshake
	input  wire logic        serviceAck,
	// Mode outputs
	output logic [31:0]      modePrimary,
	output logic [31:0]      modeSecondary,
	output logic             busMasterCond,
	output logic [3:0]       flagPinOe,
	// Interrupt request to sequencer
	output logic             irqPending,
	output logic [4:0]       irqNumber,
	output logic [31:0]      irqVector
);
	// Whole block state
	typedef struct packed {
		logic        ready;
		logic        err;
		logic [31:0] rdata;
		logic [31:0] modePri;
		logic [31:0] modeSec;
		logic [31:0] arith;
		logic [31:0] sticky;
		logic [31:0] latch;
		logic [31:0] mask;
		logic [2:0]  extPrev;
		logic        bmCond;
		logic        pend;
		logic [4:0]  num;
		logic [31:0] vec;
		logic [4:0]  inService;
		logic        busy;
	} cmsr_state_t;

	cmsr_state_t st_r;   // Registered state
	cmsr_state_t st_nxt; // Next state
	logic        wrEn;   // Write strobe
	logic        rdEn;   // Read strobe
	logic [31:0] eligible;   // Serviceable requests
	logic [31:0] sticky_nxt; // Sticky update
	logic [4:0]  bestIdx;    // Highest priority index
	logic        bestHit;    // Any serviceable

	assign wrEn = psel & penable & pwrite & st_r.ready;
	assign rdEn = psel & ~penable & ~pwrite;

	// Priority search, bit 1 highest
	always_comb begin
		bestIdx = 5'h00;
		bestHit = 1'b0;
		eligible = st_r.latch & (st_r.mask | 32'h0000_0002)
			& cmsr_pkg::IRQ_VALID;
		if (!st_r.modePri[cmsr_pkg::MP_GIE]) begin
			eligible = eligible & 32'h0000_0002;
		end
		for (int i = 31; i >= 0; i--) begin
			if (eligible[i]) begin
				bestIdx = 5'(i);
				bestHit = 1'b1;
			end
		end
		// Without nesting, only the reset interrupt preempts a running service
		if (st_r.busy && !st_r.modePri[cmsr_pkg::MP_NEST] && bestIdx != 5'h01)
		begin
			bestHit = 1'b0;
		end
		if (st_r.busy && bestIdx >= st_r.inService) begin
			bestHit = 1'b0;
		end
	end

	// Next state
	always_comb begin
		st_nxt = st_r;
		// APB: no wait state, ready in first access cycle
		st_nxt.ready = psel & ~penable;
		st_nxt.err = 1'b0;
		if (rdEn) begin
			case (paddr)
				cmsr_pkg::OFF_MODE_PRI:   st_nxt.rdata = st_r.modePri;
				cmsr_pkg::OFF_MODE_SEC:   st_nxt.rdata = st_r.modeSec
					| {cmsr_pkg::ID_CODE, cmsr_pkg::REV_CODE, 28'h0};
				cmsr_pkg::OFF_ARITH_STAT: st_nxt.rdata = st_r.arith;
				cmsr_pkg::OFF_STICKY:     st_nxt.rdata = st_r.sticky;
				cmsr_pkg::OFF_IRQ_LATCH:  st_nxt.rdata = st_r.latch;
				cmsr_pkg::OFF_IRQ_MASK:   st_nxt.rdata = st_r.mask;
				cmsr_pkg::OFF_IRQ_SERVE:
					st_nxt.rdata = {26'h0, st_r.busy, st_r.inService};
				default:                  st_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (psel & ~penable & (paddr > cmsr_pkg::OFF_IRQ_SERVE
				|| paddr[1:0] != 2'h0)) begin
			st_nxt.err = 1'b1;
		end
		// Hardware status capture
		if (arithValid) begin
			st_nxt.arith[13:0] = arithFlags;
			st_nxt.arith[31:24] = compareAccumulator;
			st_nxt.arith[18] = bitTestResult;
		end
		st_nxt.arith[cmsr_pkg::AS_FLAG +: 4] = flagPinIn;
		// Sticky: software write first, then events win
		sticky_nxt = st_r.sticky;
		if (wrEn && paddr == cmsr_pkg::OFF_STICKY) begin
			sticky_nxt = (pwdata & cmsr_pkg::STICKY_WMASK)
				| (st_r.sticky & cmsr_pkg::STICKY_RO);
		end
		sticky_nxt[2:0] = sticky_nxt[2:0] | stickyEvents[2:0];
		sticky_nxt[9:5] = sticky_nxt[9:5] | stickyEvents[7:3];
		sticky_nxt[18:17] = sticky_nxt[18:17] | stickyEvents[9:8];
		sticky_nxt[23] = sticky_nxt[23] | stackLevels[2];
		sticky_nxt[25] = sticky_nxt[25] | stackLevels[4];
		sticky_nxt[22:21] = stackLevels[1:0];
		sticky_nxt[24] = stackLevels[3];
		sticky_nxt[26] = stackLevels[5];
		st_nxt.sticky = sticky_nxt;
		// Software register writes
		if (wrEn) begin
			case (paddr)
				cmsr_pkg::OFF_MODE_PRI:
					st_nxt.modePri = pwdata & cmsr_pkg::MODE_PRI_WMASK;
				cmsr_pkg::OFF_MODE_SEC:
					st_nxt.modeSec = pwdata & cmsr_pkg::MODE_SEC_WMASK;
				cmsr_pkg::OFF_ARITH_STAT:
					st_nxt.arith = pwdata & cmsr_pkg::ARITH_WMASK;
				cmsr_pkg::OFF_IRQ_LATCH: // Reset bit is read-only
					st_nxt.latch = (pwdata & cmsr_pkg::IRQ_VALID
						& ~32'h0000_0002) | (st_r.latch & 32'h0000_0002);
				cmsr_pkg::OFF_IRQ_MASK:
					st_nxt.mask = pwdata | 32'h0000_0002;
				default: begin
				end
			endcase
		end
		// Service start clears the latch bit
		if (serviceAck && st_r.pend) begin
			st_nxt.latch[st_r.num] = 1'b0;
			st_nxt.inService = st_r.num;
			st_nxt.busy = 1'b1;
		end
		// Writing the serve register ends the service
		if (wrEn && paddr == cmsr_pkg::OFF_IRQ_SERVE) begin
			st_nxt.busy = 1'b0;
		end
		// External request sensing, active low pins
		st_nxt.extPrev = extReqN;
		for (int k = 0; k < 3; k++) begin
			if (st_r.modeSec[k] ? (st_r.extPrev[k] & ~extReqN[k])
				: ~extReqN[k]) begin
				st_nxt.latch[cmsr_pkg::IRQ_EXT_LO + 2 - k] = 1'b1;
			end
		end
		// Software event register sets latch bits
		if (wrEn && paddr == cmsr_pkg::OFF_IRQ_EVENT) begin
			st_nxt.latch = st_nxt.latch
				| (pwdata & cmsr_pkg::IRQ_VALID & ~32'h0000_0002);
		end
		// Bus-master condition gated by spare select
		st_nxt.bmCond = busMasterIn
			& (st_r.modePri[cmsr_pkg::MP_SPARE_CONDITION_SELECT_LO +: 2] == 2'h0);
		// Request outputs and vector address
		st_nxt.pend = bestHit & ~(serviceAck & st_r.pend);
		st_nxt.num = bestIdx;
		st_nxt.vec = (vecTableInternal ? cmsr_pkg::VEC_BASE_INT
			: cmsr_pkg::VEC_BASE_EXT) + {25'h0, bestIdx, 2'h0};
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
			st_r.modePri <= cmsr_pkg::MODE_PRI_RST;
			st_r.modeSec <= cmsr_pkg::MODE_SEC_RST;
			st_r.mask <= cmsr_pkg::MASK_RST;
			st_r.latch <= 32'h0000_0000;
			st_r.extPrev <= 3'h7;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops; mode bits drive the datapath
	assign pready = st_r.ready;
	assign prdata = st_r.rdata;
	assign pslverr = st_r.err;
	assign modePrimary = st_r.modePri;
	assign modeSecondary = st_r.modeSec;
	assign flagPinOe = st_r.modeSec[cmsr_pkg::MS_FLAGDIR +: 4];
	assign busMasterCond = st_r.bmCond;
	assign irqPending = st_r.pend;
	assign irqNumber = st_r.num;
	assign irqVector = st_r.vec;

	// Checks: bus answer, register effects and interrupt flow
	// A tag sits on the label line of the first assertion only

	// A setup phase is always answered in the next cycle
	apb_ready_a: assert property ( // Bus handshake, no rule
		@(posedge clk) disable iff (!rstn)
		psel && !penable |=> pready
	) else $error("setup phase not answered");

	// Latch comes out of reset empty
	latch_reset_a: assert property (
		@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> st_r.latch == 32'h0000_0000
	) else $error("latch not clear after reset");

	// Non-zero spare select kills the bus-master condition
	spare_condition_select_gate_a: assert property (
		@(posedge clk) disable iff (!rstn)
		modePrimary[cmsr_pkg::MP_SPARE_CONDITION_SELECT_LO +: 2] != 2'h0
		|=> !busMasterCond
	) else $error("condition not gated by spare select");

	// Fixed overflow stays set until software clears it
	sticky_hold_a: assert property (
		@(posedge clk) disable iff (!rstn)
		st_r.sticky[2] && !(wrEn && paddr == cmsr_pkg::OFF_STICKY)
		|=> st_r.sticky[2]
	) else $error("sticky bit lost");

	// Stack levels bypass software writes and track the core
	stack_ro_a: assert property (
		@(posedge clk) disable iff (!rstn)
		##1 st_r.sticky[22:21] == $past(stackLevels[1:0])
	) else $error("stack bits do not follow levels");

	// An event pulse always leaves its sticky bit set
	sticky_set_a: assert property (
		@(posedge clk) disable iff (!rstn)
		stickyEvents[0] |=> st_r.sticky[0]
	) else $error("sticky event lost");

	// Accepted request has its latch bit cleared
	ack_clear_a: assert property (
		@(posedge clk) disable iff (!rstn)
		serviceAck && irqPending && irqNumber != 5'h06
		&& irqNumber != 5'h07 && irqNumber != 5'h08 && !wrEn
		|=> !st_r.latch[$past(irqNumber)]
	) else $error("latch bit not cleared on accept");

	// Only the reset interrupt ignores the global enable
	gie_gate_a: assert property (
		@(posedge clk) disable iff (!rstn)
		irqPending && irqNumber != 5'h01
		|-> $past(modePrimary[cmsr_pkg::MP_GIE])
	) else $error("request without global enable");

	// A pending request must have been latched
	latch_gate_a: assert property (
		@(posedge clk) disable iff (!rstn)
		irqPending
		|-> (($past(st_r.latch) >> irqNumber) & 32'h1) != 32'h0
	) else $error("request without latch bit");

	// Masked-off sources never raise a request
	mask_gate_a: assert property (
		@(posedge clk) disable iff (!rstn)
		irqPending
		|-> (($past(st_r.mask) >> irqNumber) & 32'h1) != 32'h0
	) else $error("request from masked source");

	// Without nesting a running service blocks all but reset
	nest_block_a: assert property (
		@(posedge clk) disable iff (!rstn)
		$past(st_r.busy) && !$past(modePrimary[cmsr_pkg::MP_NEST])
		&& irqPending |-> irqNumber == 5'h01
	) else $error("service preempted without nesting");

	// Vector is the table base plus four times the number
	vec_calc_a: assert property (
		@(posedge clk) disable iff (!rstn)
		irqPending |-> irqVector == ($past(vecTableInternal)
			? cmsr_pkg::VEC_BASE_INT : cmsr_pkg::VEC_BASE_EXT)
			+ {25'h0, irqNumber, 2'h0}
	) else $error("vector address wrong");

	// Reset interrupt can never be masked
	mask_one_a: assert property (
		@(posedge clk) disable iff (!rstn)
		st_r.mask[cmsr_pkg::IRQ_RESET]
	) else $error("reset interrupt masked");

	// Flag direction follows the written direction bits
	flag_dir_a: assert property (
		@(posedge clk) disable iff (!rstn)
		wrEn && paddr == cmsr_pkg::OFF_MODE_SEC
		|=> flagPinOe == $past(pwdata[cmsr_pkg::MS_FLAGDIR +: 4])
	) else $error("flag direction not written");

	// Level mode re-latches while the pin stays low
	level_sense_a: assert property (
		@(posedge clk) disable iff (!rstn)
		!st_r.modeSec[0] && !extReqN[0]
		|=> st_r.latch[cmsr_pkg::IRQ_EXT_LO + 2]
	) else $error("level request not latched");

	// Edge mode does not re-latch a pin that stays put
	edge_sense_a: assert property (
		@(posedge clk) disable iff (!rstn)
		st_r.modeSec[1] && st_r.extPrev[1] == extReqN[1] && !wrEn
		&& !st_r.latch[cmsr_pkg::IRQ_EXT_LO + 1]
		|=> !st_r.latch[cmsr_pkg::IRQ_EXT_LO + 1]
	) else $error("edge request latched without edge");

	// Main scenarios reached
	cov_irq_c: cover property (@(posedge clk) irqPending && serviceAck);
	cov_wr_c: cover property (@(posedge clk) wrEn);
	cov_nest_c: cover property (@(posedge clk) st_r.busy && irqPending);
	cov_edge_c: cover property (@(posedge clk)
		st_r.modeSec[1] && st_r.latch[cmsr_pkg::IRQ_EXT_LO + 1]);
	cov_err_c: cover property (@(posedge clk) pready && pslverr);
endmodule : cmsr_regs
`default_nettype wire

// [rtl/cmsr_pkg.sv]
`default_nettype none
package cmsr_pkg;
	// Register byte addresses on the APB
	localparam logic [7:0] OFF_MODE_PRI   = 8'h00;
	localparam logic [7:0] OFF_MODE_SEC   = 8'h04;
	localparam logic [7:0] OFF_ARITH_STAT = 8'h08;
	localparam logic [7:0] OFF_STICKY     = 8'h0c;
	localparam logic [7:0] OFF_IRQ_LATCH  = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK   = 8'h14;
	localparam logic [7:0] OFF_IRQ_EVENT  = 8'h18;
	localparam logic [7:0] OFF_IRQ_SERVE  = 8'h1c;
	// Writable bit masks (reserved bits stay zero)
	localparam logic [31:0] MODE_PRI_WMASK = 32'h0007_fcff;
	localparam logic [31:0] MODE_SEC_WMASK = 32'h000f_8077;
	localparam logic [31:0] ARITH_WMASK    = 32'hff04_3fff;
	localparam logic [31:0] STICKY_WMASK   = 32'h0006_03e7;
	localparam logic [31:0] STICKY_RO      = 32'h07e0_0000;
	localparam logic [31:0] STICKY_LIVE    = 32'h0560_0000;
	localparam logic [31:0] IRQ_VALID      = 32'hffff_fdfa;
	// Field positions
	localparam int MP_SPARE_CONDITION_SELECT_LO = 17;
	localparam int MP_NEST    = 11;
	localparam int MP_GIE     = 12;
	localparam int MS_FLAGDIR = 15;
	localparam int AS_FLAG    = 19;
	localparam int ST_STACK   = 21;
	localparam int IRQ_RESET  = 1;
	localparam int IRQ_EXT_LO = 6;
	// Reset values
	localparam logic [31:0] MODE_PRI_RST = 32'h0000_0000;
	localparam logic [31:0] MODE_SEC_RST = 32'h0000_0000;
	localparam logic [31:0] MASK_RST     = 32'h0000_0002;
	// Silicon revision and processor id, values arbitrary
	localparam logic [1:0]  REV_CODE = 2'h3;
	localparam logic [1:0]  ID_CODE  = 2'h0;
	// Vector table bases
	localparam logic [31:0] VEC_BASE_INT = 32'h0002_0000;
	localparam logic [31:0] VEC_BASE_EXT = 32'h0040_0000;
endpackage : cmsr_pkg
`default_nettype wire

// [dv/tb.sv]
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Clock, reset and APB
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	// Core side inputs
	logic [13:0] arithFlags;
	logic        arithValid, bitTestResult, busMasterIn;
	logic        vecTableInternal, serviceAck, busMasterCond, irqPending;
	logic [7:0]  compareAccumulator;
	logic [3:0]  flagPinIn, flagPinOe;
	logic [9:0]  stickyEvents;
	logic [5:0]  stackLevels;
	logic [2:0]  extReqN;
	logic [31:0] modePrimary, modeSecondary, irqVector;
	logic [4:0]  irqNumber;
	logic        err;
	int          n_mismatch, samples_checked, cycles;

	cmsr_regs i_cmsr_regs (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.arithFlags(arithFlags), .arithValid(arithValid),
		.bitTestResult(bitTestResult), .compareAccumulator(compareAccumulator),
		.flagPinIn(flagPinIn), .stickyEvents(stickyEvents),
		.stackLevels(stackLevels), .extReqN(extReqN),
		.busMasterIn(busMasterIn), .vecTableInternal(vecTableInternal),
		.serviceAck(serviceAck), .modePrimary(modePrimary),
		.modeSecondary(modeSecondary), .busMasterCond(busMasterCond),
		.flagPinOe(flagPinOe), .irqPending(irqPending),
		.irqNumber(irqNumber), .irqVector(irqVector));

	// Free running clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_mismatch++;
			results();
		end
	end

	// Compare and count
	task automatic check(input logic [31:0] got, exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : check

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// Mode registers, masking, condition select, flag direction
	task automatic t_mode;
		apb(0, cmsr_pkg::OFF_MODE_SEC, 0);
		check(rd, {cmsr_pkg::ID_CODE, cmsr_pkg::REV_CODE, 28'h0}, "sec rst");
		check({31'h0, busMasterCond}, 32'h1, "bm cond on");
		apb(1, cmsr_pkg::OFF_MODE_PRI, cmsr_pkg::MODE_PRI_WMASK);
		apb(0, cmsr_pkg::OFF_MODE_PRI, 0);
		check(rd, cmsr_pkg::MODE_PRI_WMASK, "pri mask");
		check(modePrimary, cmsr_pkg::MODE_PRI_WMASK, "pri out");
		check({31'h0, busMasterCond}, 32'h0, "bm cond off");
		apb(1, cmsr_pkg::OFF_MODE_SEC, 32'h0000_8000);
		check({28'h0, flagPinOe}, 32'h1, "flag dir");
		check(modeSecondary, 32'h0000_8000, "sec out");
		apb(1, cmsr_pkg::OFF_MODE_PRI, 32'h0000_1000);
	endtask : t_mode

	// Status capture and sticky behaviour
	task automatic t_status;
		arithFlags <= 14'h2aaa;
		arithValid <= 1'b1;
		stackLevels <= 6'h3f;
		stickyEvents <= 10'h3ff;
		@(posedge clk);
		arithValid <= 1'b0;
		stickyEvents <= 10'h0;
		@(posedge clk);
		stackLevels <= 6'h0;
		apb(0, cmsr_pkg::OFF_ARITH_STAT, 0);
		check(rd, 32'ha54c_2aaa, "arith");
		apb(0, cmsr_pkg::OFF_STICKY, 0);
		check(rd, 32'h0286_03e7, "sticky hold");
		apb(1, cmsr_pkg::OFF_STICKY, 0);
		apb(0, cmsr_pkg::OFF_STICKY, 0);
		check(rd, 32'h0280_0000, "sticky ro");
		apb(0, 8'h20, 0);
		check({rd[30:0], err}, 32'h1, "unmapped");
	endtask : t_status

	// Priority, vectors, acknowledge, external request
	task automatic t_irq;
		apb(0, cmsr_pkg::OFF_IRQ_MASK, 0);
		check(rd, cmsr_pkg::MASK_RST, "mask rst");
		apb(1, cmsr_pkg::OFF_IRQ_MASK, 32'h1100_0000);
		apb(1, cmsr_pkg::OFF_IRQ_EVENT, 32'h1100_0000);
		@(posedge clk);
		check({27'h0, irqNumber}, 32'h18, "prio");
		check({31'h0, irqPending}, 32'h1, "pending");
		check(irqVector, cmsr_pkg::VEC_BASE_INT + 32'h60, "vec int");
		vecTableInternal <= 1'b0;
		repeat (2) @(posedge clk);
		check(irqVector, cmsr_pkg::VEC_BASE_EXT + 32'h60, "vec ext");
		serviceAck <= 1'b1;
		@(posedge clk);
		serviceAck <= 1'b0;
		apb(0, cmsr_pkg::OFF_IRQ_LATCH, 0);
		check(rd, 32'h1000_0000, "ack clr");
		check({31'h0, irqPending}, 32'h0, "no nest");
		apb(1, cmsr_pkg::OFF_IRQ_SERVE, 0);
		apb(1, cmsr_pkg::OFF_IRQ_LATCH, 0);
		extReqN <= 3'b110;
		repeat (2) @(posedge clk);
		extReqN <= 3'b111;
		apb(0, cmsr_pkg::OFF_IRQ_LATCH, 0);
		check(rd, 32'h0000_0100, "ext req");
		check({31'h0, irqPending}, 32'h0, "masked");
		// Edge mode on the second request pin latches once per edge
		apb(1, cmsr_pkg::OFF_MODE_SEC, 32'h0000_8002);
		apb(1, cmsr_pkg::OFF_IRQ_LATCH, 0);
		extReqN <= 3'b101;
		repeat (2) @(posedge clk);
		apb(0, cmsr_pkg::OFF_IRQ_LATCH, 0);
		check(rd, 32'h0000_0080, "edge set");
		apb(1, cmsr_pkg::OFF_IRQ_LATCH, 0);
		apb(0, cmsr_pkg::OFF_IRQ_LATCH, 0);
		check(rd, 32'h0000_0000, "edge once");
		extReqN <= 3'h7;
	endtask : t_irq

	// Report and stop
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// Main sequence
	initial begin
		{rstn, psel, penable, pwrite, arithValid, serviceAck} = 6'h0;
		{paddr, pwdata, arithFlags, stickyEvents, stackLevels} = '0;
		{bitTestResult, busMasterIn, vecTableInternal} = 3'h7;
		compareAccumulator = 8'ha5;
		flagPinIn = 4'h9;
		extReqN = 3'h7;
		{n_mismatch, samples_checked, cycles} = '0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_mode();
		t_status();
		t_irq();
		results();
	end
endmodule : tb
`default_nettype wire
